// ---- common/plb_pkg.sv ----
// Constants, field layouts and carrier types of the programmable logic block.
package plb_pkg;

   // ----------------------------------------------------------------
   // Array dimensions
   // ----------------------------------------------------------------
   localparam int unsigned NUM_IN     = 36;
   localparam int unsigned NUM_MC     = 16;
   localparam int unsigned PAL_PER_MC = 5;
   localparam int unsigned NUM_PLA    = 32;
   localparam int unsigned NUM_CT     = 6;
   localparam int unsigned NUM_CLK    = 4;
   localparam int unsigned NUM_FBK    = 2 * NUM_MC;
   localparam int unsigned PAL_TERMS  = NUM_MC * PAL_PER_MC;
   localparam int unsigned CT_BASE    = PAL_TERMS + NUM_PLA;
   localparam int unsigned NUM_TERMS  = CT_BASE + NUM_CT;
   localparam int unsigned HIGH_W     = NUM_IN - 32;

   // ----------------------------------------------------------------
   // Control term roles and output enable selections
   // ----------------------------------------------------------------
   localparam int unsigned CT_RESET   = 0;
   localparam int unsigned CT_PRESET  = 1;
   localparam int unsigned CT_OE_BASE = 2;
   localparam logic [2:0]  OE_ON      = 3'h4;
   localparam logic [2:0]  OE_OFF     = 3'h5;

   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W      = 12;
   localparam int unsigned IDX_LSB     = 2;
   localparam int unsigned TERM_LSB    = 4;
   localparam int unsigned BLK_LSB     = 6;
   localparam logic [11:0] ADDR_CTRL   = 12'h800;
   localparam logic [11:0] ADDR_CLKSRC = 12'h804;
   localparam logic [11:0] ADDR_CTMODE = 12'h808;
   localparam logic [11:0] ADDR_STATUS = 12'h80C;
   localparam logic [11:0] ADDR_MCCFG  = 12'h840;
   localparam logic [11:0] ADDR_PLAOR  = 12'h880;
   localparam logic [1:0]  WORD_LIT    = 2'h0;
   localparam logic [1:0]  WORD_LITN   = 2'h1;
   localparam logic [1:0]  WORD_HIGH   = 2'h2;
   localparam int unsigned CTRL_FLOAT_EN = 0;
   localparam int unsigned CLKSEL_W    = 4;
   localparam int unsigned MCCFG_W     = 8;
   localparam logic [31:0] RESET_VAL   = 32'h0000_0000;

   // Per-macrocell configuration word.
   typedef struct packed {
      logic [2:0] oeSel;
      logic       prEnable;
      logic [1:0] clkSel;
      logic       fallEdge;
      logic       toggle;
   } plb_mc_cfg_t;

   // One programmable AND/OR term: true and complement literal masks.
   typedef struct packed {
      logic [NUM_IN-1:0] lit;
      logic [NUM_IN-1:0] litN;
   } plb_term_t;

endpackage : plb_pkg

// ---- hdl/plb_logic_block.sv ----
// One programmable logic block: term arrays, sixteen macrocells and a register slave.
`timescale 1ns/10ps
module plb_logic_block (
   input  wire logic                        clk,
   input  wire logic                        resetn,
   input  wire logic [plb_pkg::ADDR_W-1:0]  address,
   input  wire logic                        read,
   input  wire logic                        write,
   input  wire logic [31:0]                 writedata,
   input  wire logic [3:0]                  byteenable,
   output logic      [31:0]                 readdata,
   output logic                             waitrequest,
   input  wire logic [plb_pkg::NUM_IN-1:0]  matrixIn,
   output logic      [plb_pkg::NUM_FBK-1:0] matrixFeedback,
   input  wire logic                        pinOnlyClock,
   input  wire logic                        selectableClockA,
   input  wire logic                        selectableClockB,
   input  wire logic                        selectableClockC,
   input  wire logic                        globalFloatPinN,
   input  wire logic [plb_pkg::NUM_MC-1:0]  pinIn,
   output logic      [plb_pkg::NUM_MC-1:0]  pinOut,
   output logic      [plb_pkg::NUM_MC-1:0]  pinOe
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   plb_pkg::plb_term_t             termMem [plb_pkg::NUM_TERMS];
   plb_pkg::plb_mc_cfg_t           mcCfgQ  [plb_pkg::NUM_MC];
   logic [plb_pkg::NUM_PLA-1:0]    plaOrQ  [plb_pkg::NUM_MC];
   logic [31:0]                    ctrlQ;
   logic [31:0]                    clkSrcQ;
   logic [plb_pkg::NUM_CT-1:0]     ctModeQ;
   logic                           ackQ;
   logic [31:0]                    readdataQ;
   logic [31:0]                    rdMux;
   logic [31:0]                    wrData;
   logic                           wrFire;
   logic                           termHit;
   logic [6:0]                     termIdx;
   logic [3:0]                     regIdx;
   logic [plb_pkg::NUM_CLK-1:0]    clkSync1Q;
   logic [plb_pkg::NUM_CLK-1:0]    clkSync2Q;
   logic [plb_pkg::NUM_CLK-1:0]    clkPrevQ;
   logic [plb_pkg::NUM_CLK-1:0]    clkLevel;
   logic [plb_pkg::NUM_CLK-1:0]    clkRise;
   logic [plb_pkg::NUM_CLK-1:0]    clkFall;
   logic [plb_pkg::NUM_MC-1:0]     pinSync1Q;
   logic [plb_pkg::NUM_MC-1:0]     pinSync2Q;
   logic                           floatSync1Q;
   logic                           floatSync2Q;
   logic                           floatNow;
   logic [plb_pkg::PAL_TERMS-1:0]  palVal;
   logic [plb_pkg::NUM_PLA-1:0]    plaVal;
   logic [plb_pkg::NUM_CT-1:0]     ctOut;
   logic [plb_pkg::NUM_MC-1:0]     sumVal;
   logic [plb_pkg::NUM_MC-1:0]     mcEvt;
   logic [plb_pkg::NUM_MC-1:0]     prHit;
   logic [plb_pkg::NUM_MC-1:0]     oeNext;
   logic [plb_pkg::NUM_MC-1:0]     mcQ;
   logic [plb_pkg::NUM_MC-1:0]     pinOeQ;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // AND of the selected literals; a term with no literal reads as zero.
   function automatic logic prodTerm(plb_pkg::plb_term_t t, logic [plb_pkg::NUM_IN-1:0] x);
      return (|(t.lit | t.litN)) & (&((~t.lit | x) & (~t.litN | ~x)));
   endfunction : prodTerm

   // OR of the selected literals.
   function automatic logic sumTerm(plb_pkg::plb_term_t t, logic [plb_pkg::NUM_IN-1:0] x);
      return |((t.lit & x) | (t.litN & ~x));
   endfunction : sumTerm

   // Byte-lane merge of new write data over the current register value.
   function automatic logic [31:0] mergeBytes(logic [31:0] old, logic [31:0] wd,
                                              logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction : mergeBytes

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------

   // Every access takes one wait state, then completes on the next edge.
   assign waitrequest = (read | write) & ~ackQ;
   assign wrFire      = write & ackQ;
   assign readdata    = readdataQ;
   assign termIdx     = address[plb_pkg::ADDR_W-2:plb_pkg::TERM_LSB];
   assign regIdx      = address[plb_pkg::BLK_LSB-1:plb_pkg::IDX_LSB];
   assign termHit     = ~address[plb_pkg::ADDR_W-1] && (termIdx < plb_pkg::NUM_TERMS) &&
                        (address[plb_pkg::TERM_LSB-1:plb_pkg::IDX_LSB] != 2'h3);
   assign wrData      = mergeBytes(rdMux, writedata, byteenable);

   // Acknowledge toggles the wait state off for exactly one cycle.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ackQ <= 1'b0;
      end else begin
         ackQ <= (read | write) & ~ackQ;
      end
   end

   // Read data is captured in the wait cycle and held until the next read.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         readdataQ <= plb_pkg::RESET_VAL;
      end else if (read && !ackQ) begin
         readdataQ <= rdMux;
      end
   end

   // Read-back multiplexer; unmapped addresses read as zero.
   always_comb begin
      rdMux = plb_pkg::RESET_VAL;
      if (termHit) begin
         unique case (address[plb_pkg::TERM_LSB-1:plb_pkg::IDX_LSB])
            plb_pkg::WORD_LIT:  rdMux = termMem[termIdx].lit[31:0];
            plb_pkg::WORD_LITN: rdMux = termMem[termIdx].litN[31:0];
            default: begin
               rdMux[plb_pkg::HIGH_W-1:0] = termMem[termIdx].lit[plb_pkg::NUM_IN-1:32];
               rdMux[2*plb_pkg::HIGH_W-1:plb_pkg::HIGH_W] =
                  termMem[termIdx].litN[plb_pkg::NUM_IN-1:32];
            end
         endcase
      end else if (address == plb_pkg::ADDR_CTRL) begin
         rdMux = ctrlQ;
      end else if (address == plb_pkg::ADDR_CLKSRC) begin
         rdMux = clkSrcQ;
      end else if (address == plb_pkg::ADDR_CTMODE) begin
         rdMux[plb_pkg::NUM_CT-1:0] = ctModeQ;
      end else if (address == plb_pkg::ADDR_STATUS) begin
         rdMux = {pinSync2Q, mcQ};
      end else if (address[plb_pkg::ADDR_W-1:plb_pkg::BLK_LSB] ==
                   plb_pkg::ADDR_MCCFG[plb_pkg::ADDR_W-1:plb_pkg::BLK_LSB]) begin
         rdMux[plb_pkg::MCCFG_W-1:0] = mcCfgQ[regIdx];
      end else if (address[plb_pkg::ADDR_W-1:plb_pkg::BLK_LSB] ==
                   plb_pkg::ADDR_PLAOR[plb_pkg::ADDR_W-1:plb_pkg::BLK_LSB]) begin
         rdMux = plaOrQ[regIdx];
      end
   end

   // Term array programming; a write lands at the completing edge.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int t = 0; t < plb_pkg::NUM_TERMS; t++) begin
            termMem[t] <= '0;
         end
      end else if (wrFire && termHit) begin
         unique case (address[plb_pkg::TERM_LSB-1:plb_pkg::IDX_LSB])
            plb_pkg::WORD_LIT:  termMem[termIdx].lit[31:0]  <= wrData;
            plb_pkg::WORD_LITN: termMem[termIdx].litN[31:0] <= wrData;
            default: begin
               termMem[termIdx].lit[plb_pkg::NUM_IN-1:32]  <= wrData[plb_pkg::HIGH_W-1:0];
               termMem[termIdx].litN[plb_pkg::NUM_IN-1:32] <=
                  wrData[2*plb_pkg::HIGH_W-1:plb_pkg::HIGH_W];
            end
         endcase
      end
   end

   // Block-wide and per-macrocell configuration registers.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrlQ   <= plb_pkg::RESET_VAL;
         clkSrcQ <= plb_pkg::RESET_VAL;
         ctModeQ <= '0;
         for (int m = 0; m < plb_pkg::NUM_MC; m++) begin
            mcCfgQ[m] <= '0;
            plaOrQ[m] <= '0;
         end
      end else if (wrFire && !termHit) begin
         if (address == plb_pkg::ADDR_CTRL) begin
            ctrlQ <= wrData;
         end else if (address == plb_pkg::ADDR_CLKSRC) begin
            clkSrcQ <= wrData;
         end else if (address == plb_pkg::ADDR_CTMODE) begin
            ctModeQ <= wrData[plb_pkg::NUM_CT-1:0];
         end else if (address[plb_pkg::ADDR_W-1:plb_pkg::BLK_LSB] ==
                      plb_pkg::ADDR_MCCFG[plb_pkg::ADDR_W-1:plb_pkg::BLK_LSB]) begin
            mcCfgQ[regIdx] <= plb_pkg::plb_mc_cfg_t'(wrData[plb_pkg::MCCFG_W-1:0]);
         end else if (address[plb_pkg::ADDR_W-1:plb_pkg::BLK_LSB] ==
                      plb_pkg::ADDR_PLAOR[plb_pkg::ADDR_W-1:plb_pkg::BLK_LSB]) begin
            plaOrQ[regIdx] <= wrData;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------

   // Clock, I/O and float pins pass two flops before any logic sees them.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         clkSync1Q   <= '0;
         clkSync2Q   <= '0;
         pinSync1Q   <= '0;
         pinSync2Q   <= '0;
         floatSync1Q <= 1'b1;
         floatSync2Q <= 1'b1;
      end else begin
         clkSync1Q   <= {selectableClockC, selectableClockB, selectableClockA, pinOnlyClock};
         clkSync2Q   <= clkSync1Q;
         pinSync1Q   <= pinIn;
         pinSync2Q   <= pinSync1Q;
         floatSync1Q <= globalFloatPinN;
         floatSync2Q <= floatSync1Q;
      end
   end

   // ----------------------------------------------------------------
   // Clock sources
   // ----------------------------------------------------------------

   always_comb begin
      clkLevel[0] = clkSync2Q[0];
      for (int k = 1; k < plb_pkg::NUM_CLK; k++) begin
         clkLevel[k] = clkSrcQ[k] ? mcQ[clkSrcQ[plb_pkg::CLKSEL_W*k +: plb_pkg::CLKSEL_W]]
                                  : clkSync2Q[k];
      end
   end

   // Previous clock levels give one-cycle rising and falling edge events.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         clkPrevQ <= '0;
      end else begin
         clkPrevQ <= clkLevel;
      end
   end

   assign clkRise = clkLevel & ~clkPrevQ;
   assign clkFall = ~clkLevel & clkPrevQ;

   // ----------------------------------------------------------------
   // Term arrays and macrocell sums
   // ----------------------------------------------------------------

   always_comb begin
      for (int t = 0; t < plb_pkg::PAL_TERMS; t++) begin
         palVal[t] = prodTerm(termMem[t], matrixIn);
      end
      for (int p = 0; p < plb_pkg::NUM_PLA; p++) begin
         plaVal[p] = prodTerm(termMem[plb_pkg::PAL_TERMS + p], matrixIn);
      end
      for (int c = 0; c < plb_pkg::NUM_CT; c++) begin
         ctOut[c] = ctModeQ[c] ? sumTerm(termMem[plb_pkg::CT_BASE + c], matrixIn)
                               : prodTerm(termMem[plb_pkg::CT_BASE + c], matrixIn);
      end
      for (int m = 0; m < plb_pkg::NUM_MC; m++) begin
         sumVal[m] = (|palVal[m*plb_pkg::PAL_PER_MC +: plb_pkg::PAL_PER_MC]) |
                     (|(plaVal & plaOrQ[m]));
      end
   end

   always_comb begin
      for (int m = 0; m < plb_pkg::NUM_MC; m++) begin
         mcEvt[m] = mcCfgQ[m].fallEdge ? clkFall[mcCfgQ[m].clkSel] : clkRise[mcCfgQ[m].clkSel];
         prHit[m] = mcCfgQ[m].prEnable & (ctOut[plb_pkg::CT_RESET] | ctOut[plb_pkg::CT_PRESET]);
      end
   end

   // ----------------------------------------------------------------
   // Macrocell flip-flops
   // ----------------------------------------------------------------

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mcQ <= '0;
      end else begin
         for (int m = 0; m < plb_pkg::NUM_MC; m++) begin
            if (prHit[m] && ctOut[plb_pkg::CT_RESET]) begin
               mcQ[m] <= 1'b0;
            end else if (prHit[m]) begin
               mcQ[m] <= 1'b1;
            end else if (mcEvt[m]) begin
               mcQ[m] <= mcCfgQ[m].toggle ? (mcQ[m] ^ sumVal[m]) : sumVal[m];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Output buffers and feedback
   // ----------------------------------------------------------------

   assign floatNow = ctrlQ[plb_pkg::CTRL_FLOAT_EN] & ~floatSync2Q;

   always_comb begin
      for (int m = 0; m < plb_pkg::NUM_MC; m++) begin
         if (mcCfgQ[m].oeSel < plb_pkg::OE_ON) begin
            oeNext[m] = ctOut[plb_pkg::CT_OE_BASE + int'(mcCfgQ[m].oeSel)];
         end else begin
            oeNext[m] = (mcCfgQ[m].oeSel == plb_pkg::OE_ON);
         end
         oeNext[m] = oeNext[m] & ~floatNow;
      end
   end

   // Output enables are registered so the pins change cleanly.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pinOeQ <= '0;
      end else begin
         pinOeQ <= oeNext;
      end
   end

   assign pinOut = mcQ;
   assign pinOe  = pinOeQ;

   assign matrixFeedback = {pinSync2Q, mcQ};

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   property p_por_clear;
      @(posedge clk) !resetn |=> (mcQ == '0 && pinOe == '0);
   endproperty
   a_por_clear: assert property (p_por_clear)
      else $error("Macrocells not cleared by reset.");

   property p_float;
      @(posedge clk) disable iff (!resetn) floatNow |=> (pinOe == '0);
   endproperty
   a_float: assert property (p_float)
      else $error("Output enabled while global float active.");

   property p_oe_off;
      @(posedge clk) disable iff (!resetn)
         (mcCfgQ[0].oeSel == plb_pkg::OE_OFF) |=> !pinOe[0];
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("Forced-off buffer drove its pin.");

   property p_reset_wins;
      @(posedge clk) disable iff (!resetn)
         (mcCfgQ[0].prEnable && ctOut[plb_pkg::CT_RESET]) |=> !mcQ[0];
   endproperty
   a_reset_wins: assert property (p_reset_wins)
      else $error("Reset term did not clear the cell.");

   property p_preset;
      @(posedge clk) disable iff (!resetn)
         (mcCfgQ[0].prEnable && ctOut[plb_pkg::CT_PRESET] && !ctOut[plb_pkg::CT_RESET])
         |=> mcQ[0];
   endproperty
   a_preset: assert property (p_preset)
      else $error("Preset term did not set the cell.");

   property p_toggle;
      @(posedge clk) disable iff (!resetn)
         (mcEvt[0] && mcCfgQ[0].toggle && !prHit[0] && sumVal[0]) |=> (mcQ[0] != $past(mcQ[0]));
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("Toggle cell did not flip.");

   property p_dcapture;
      @(posedge clk) disable iff (!resetn)
         (mcEvt[0] && !mcCfgQ[0].toggle && !prHit[0]) |=> (mcQ[0] == $past(sumVal[0]));
   endproperty
   a_dcapture: assert property (p_dcapture)
      else $error("D cell did not capture its sum.");

   property p_hold;
      @(posedge clk) disable iff (!resetn) (!mcEvt[0] && !prHit[0]) |=> $stable(mcQ[0]);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Cell changed without its clock edge.");

   property p_bus_wait;
      @(posedge clk) disable iff (!resetn) $rose(read | write) |-> waitrequest ##1 !waitrequest;
   endproperty
   a_bus_wait: assert property (p_bus_wait)
      else $error("Bus access did not finish after one wait state.");

endmodule : plb_logic_block

// ---- dv/plb_board_model.sv ----
// Board-side model: clock sources and pulled-up I/O pins around the logic block.
`timescale 1ns/10ps
module plb_board_model (
   input  wire logic        clk,
   input  wire logic [15:0] pinOut,
   input  wire logic [15:0] pinOe,
   output logic      [3:0]  clkPins,
   output logic      [15:0] pinIn
);
   logic [15:0] extEn  = 16'h0000;
   logic [15:0] extVal = 16'h0000;
   initial clkPins = 4'h0;
   // Pin level comes from the device, else the board driver, else the pull-up.
   // input pin level
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pinIn[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'b1);
      end
   end
   // Moves one clock pin and holds it eight cycles so the synchroniser sees it.
   // pin clocks
   task automatic set_clk(input int k, input logic v);
      @(posedge clk);
      clkPins[k] <= v;
      repeat (8) @(posedge clk);
   endtask : set_clk
   // Drives or releases one pin from the board side.
   task automatic drive_pin(input int i, input logic en, input logic v);
      @(posedge clk);
      extEn[i]  <= en;
      extVal[i] <= v;
   endtask : drive_pin
endmodule : plb_board_model

// ---- dv/testbench.sv ----
// Self-checking bench for the programmable logic block and its board model.
`timescale 1ns/10ps
module testbench;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [11:0] address = 12'h000;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0]  byteenable = 4'hF;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [35:0] matrixIn = 36'h0_0000_0000;
   logic [31:0] matrixFeedback;
   logic        globalFloatPinN = 1'b1;
   logic [15:0] pinIn;
   logic [15:0] pinOut;
   logic [15:0] pinOe;
   logic [3:0]  clkPins;
   logic [31:0] rd;
   int          n_mismatch = 0;
   int          num_checks = 0;
   // Register rows: address, written value, expected read-back.
   logic [11:0] rowA [7] = '{12'h000, 12'h028, 12'h808, 12'h840, 12'h880, 12'h00C, 12'h80C};
   logic [31:0] rowD [7] = '{32'h8000_0001, 32'h0000_00F5, 32'h0000_0010, 32'h0000_00A5,
                             32'h0000_0003, 32'h1234_5678, 32'h0000_FFFF};
   logic [31:0] rowE [7] = '{32'h8000_0001, 32'h0000_00F5, 32'h0000_0010, 32'h0000_00A5,
                             32'h0000_0003, 32'h0000_0000, 32'hFFFF_0000};

   always #25 clk = ~clk;

   plb_logic_block uut (
      .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .matrixIn(matrixIn), .matrixFeedback(matrixFeedback),
      .pinOnlyClock(clkPins[0]), .selectableClockA(clkPins[1]),
      .selectableClockB(clkPins[2]), .selectableClockC(clkPins[3]),
      .globalFloatPinN(globalFloatPinN), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe)
   );

   plb_board_model board (
      .clk(clk), .pinOut(pinOut), .pinOe(pinOe), .clkPins(clkPins), .pinIn(pinIn)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // Compares one value and counts it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One Avalon access held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      read      <= ~wr;
      write     <= wr;
      address   <= a;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      if (waitrequest !== 1'b0) begin
         n_mismatch++;
         wrap_up();
      end
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask : rdc
   // Waits n edges plus half a cycle so outputs are settled.
   task automatic st(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : st
   task automatic mi(input logic [35:0] v);
      @(posedge clk);
      matrixIn <= v;
   endtask : mi

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      st(0);
      chk({pinOe, pinOut}, 32'h0000_0000);
      chk(32'(matrixFeedback[15:0]), 32'h0000_0000);
      // Register rows, then cleared again.
      for (int i = 0; i < 7; i++) begin
         wr(rowA[i], rowD[i]);
         rdc(rowA[i], rowE[i]);
      end
      for (int i = 0; i < 5; i++) wr(rowA[i], 32'h0000_0000);
      @(posedge clk);
      byteenable <= 4'h1;
      wr(12'h8BC, 32'hFFFF_FFFF);
      @(posedge clk);
      byteenable <= 4'hF;
      rdc(12'h8BC, 32'h0000_00FF);
      // D capture on the pin-only clock, then toggle, then falling edge.
      wr(12'h000, 32'h0000_0001);
      wr(12'h840, 32'h0000_0080);
      mi(36'h0_0000_0001);
      board.set_clk(0, 1'b1);
      st(0);
      chk(32'({pinOe[0], pinOut[0], matrixFeedback[0]}), 32'h0000_0007);
      wr(12'h840, 32'h0000_0081);
      board.set_clk(0, 1'b0);
      board.set_clk(0, 1'b1);
      st(0);
      chk(32'(pinOut[0]), 32'h0000_0000);
      wr(12'h840, 32'h0000_0083);
      board.set_clk(0, 1'b0);
      st(0);
      chk(32'(pinOut[0]), 32'h0000_0001);
      board.set_clk(0, 1'b1);
      st(0);
      chk(32'(pinOut[0]), 32'h0000_0001);
      // Cell 1 clocks cell 0; one shared term feeds cells 2 and 3.
      wr(12'h050, 32'h0000_0002);
      wr(12'h500, 32'h0000_0004);
      wr(12'h888, 32'h0000_0001);
      wr(12'h88C, 32'h0000_0001);
      wr(12'h804, 32'h0000_0012);
      wr(12'h840, 32'h0000_0084);
      mi(36'h0_0000_0006);
      board.set_clk(0, 1'b0);
      board.set_clk(0, 1'b1);
      st(0);
      chk(32'(pinOut[3:0]), 32'h0000_000E);
      // Preset as product then sum term, reset winning, then disabled.
      wr(12'h700, 32'h0000_0008);
      wr(12'h710, 32'h0000_0030);
      wr(12'h840, 32'h0000_0090);
      mi(36'h0_0000_0010);
      st(6);
      chk(32'(pinOut[1:0]), 32'h0000_0002);
      wr(12'h808, 32'h0000_0002);
      st(6);
      chk(32'(pinOut[1:0]), 32'h0000_0003);
      mi(36'h0_0000_0018);
      st(6);
      chk(32'(pinOut[1:0]), 32'h0000_0002);
      wr(12'h840, 32'h0000_0080);
      mi(36'h0_0000_0010);
      st(6);
      chk(32'(pinOut[1:0]), 32'h0000_0002);
      // Each of the four enable terms drives the buffer, then forced off.
      for (int k = 0; k < 4; k++) begin
         wr(12'h720 + 12'(k * 16), 32'h0000_0040 << k);
         wr(12'h840, 32'(k) << 5);
         mi(36'h0_0000_0040 << k);
         st(6);
         chk(32'(pinOe[0]), 32'h0000_0001);
         mi(36'h0_0000_0000);
         st(6);
         chk(32'(pinOe[0]), 32'h0000_0000);
      end
      wr(12'h840, 32'h0000_00A0);
      mi(36'h0_0000_0040);
      st(6);
      chk(32'(pinOe[0]), 32'h0000_0000);
      // Global float pin, disabled then enabled, with the pin read back.
      mi(36'h0_0000_0000);
      wr(12'h840, 32'h0000_0080);
      @(posedge clk);
      globalFloatPinN <= 1'b0;
      st(6);
      chk(32'(pinOe[0]), 32'h0000_0001);
      wr(12'h800, 32'h0000_0001);
      st(6);
      chk(32'(pinOe), 32'h0000_0000);
      chk(32'({matrixFeedback[16], matrixFeedback[0]}), 32'h0000_0002);
      board.drive_pin(0, 1'b1, 1'b0);
      st(6);
      chk(32'(matrixFeedback[16]), 32'h0000_0000);
      board.drive_pin(0, 1'b0, 1'b0);
      @(posedge clk);
      globalFloatPinN <= 1'b1;
      st(6);
      chk(32'(pinOe[0]), 32'h0000_0001);
      // Reset in mid-run clears set cells, enables and configuration.
      @(posedge clk);
      resetn <= 1'b0;
      st(3);
      chk({pinOe, pinOut}, 32'h0000_0000);
      @(posedge clk);
      resetn <= 1'b1;
      st(2);
      chk(32'(matrixFeedback[15:0]), 32'h0000_0000);
      rdc(12'h840, 32'h0000_0000);
      // Toggle cell 0 once from each selectable pin clock in turn.
      wr(12'h000, 32'h0000_0001);
      mi(36'h0_0000_0001);
      for (int k = 1; k < 4; k++) begin
         wr(12'h840, 32'h0000_0081 | (32'(k) << 2));
         board.set_clk(k, 1'b1);
         st(0);
         chk(32'(pinOut[0]), 32'(k & 1));
      end
      wrap_up();
   end
endmodule : testbench
